// ===== src/pwrs_pkg.sv
// package: register map, field layout, timing and state codes of the power sequencer
package pwrs_pkg;

    // ------------------------------------------------------------------
    // bus shape
    // ------------------------------------------------------------------
    localparam int AXI_ADDR_W = 8;
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;
    localparam logic [1:0] RESP_DECERR = 2'h3;

    // ------------------------------------------------------------------
    // register byte offsets
    // ------------------------------------------------------------------
    localparam logic [AXI_ADDR_W-1:0] REG_STATUS = 8'h00;
    localparam logic [AXI_ADDR_W-1:0] REG_RELEASE_TIME = 8'h04;
    localparam logic [AXI_ADDR_W-1:0] REG_FINE_SENS = 8'h08;
    localparam logic [AXI_ADDR_W-1:0] REG_ZERO_TRIM = 8'h0C;
    localparam logic [AXI_ADDR_W-1:0] REG_LOCK_CTRL = 8'h10;
    localparam logic [AXI_ADDR_W-1:0] REG_UNLOCK_CODE = 8'h24;

    // ------------------------------------------------------------------
    // field positions and widths
    // ------------------------------------------------------------------
    localparam int STATUS_STATE_LSB = 0;
    localparam int STATUS_UNLOCKED_BIT = 8;
    localparam int STATUS_PERMLOCK_BIT = 9;
    localparam int STATUS_WINDOW_BIT = 10;
    localparam int LOCK_CTRL_BIT = 0;
    localparam int UNLOCK_CODE_W = 30;
    localparam int COUNT_W = 16;
    localparam int WINDOW_W = 20;

    // ------------------------------------------------------------------
    // timing in printed units and in cycles of the 125 MHz clock
    // ------------------------------------------------------------------
    localparam int CLOCK_MHZ = 125;
    localparam int UNLOCK_WINDOW_MS = 8;
    localparam int UNLOCK_WINDOW_CYCLES = UNLOCK_WINDOW_MS * 1000 * CLOCK_MHZ;
    localparam int LOCKOUT_ENABLE_US = 64;
    localparam int LOCKOUT_ENABLE_CYCLES = LOCKOUT_ENABLE_US * CLOCK_MHZ;
    localparam int LOCKOUT_DISABLE_US = 64;
    localparam int LOCKOUT_DISABLE_CYCLES = LOCKOUT_DISABLE_US * CLOCK_MHZ;
    localparam int POWER_ON_RELEASE_US = 16;
    localparam logic [COUNT_W-1:0] RELEASE_TIME_RESET =
        16'(POWER_ON_RELEASE_US * CLOCK_MHZ);
    localparam int TRIM_W_DEFAULT = 9;

    // ------------------------------------------------------------------
    // output sequencing states
    // ------------------------------------------------------------------
    typedef enum logic [5:0] {
        ST_HIZ = 6'h01,
        ST_RELEASE = 6'h02,
        ST_NORMAL = 6'h04,
        ST_UV_PEND = 6'h08,
        ST_LOCKOUT = 6'h10,
        ST_UV_EXIT = 6'h20
    } pwrs_state_e;

endpackage : pwrs_pkg

// ===== src/pwrs_flag_sync.sv
// module: three-stage synchroniser with agreement filter for comparator flags
`timescale 1ns/1ps
`default_nettype none

module pwrs_flag_sync #(
    parameter int WIDTH = 4
) (
    input wire logic clock,
    input wire logic reset,
    input wire logic [WIDTH-1:0] asyncIn,
    output logic [WIDTH-1:0] syncOut
);
    import pwrs_pkg::*;

    typedef struct packed {
        logic [WIDTH-1:0] s1;
        logic [WIDTH-1:0] s2;
        logic [WIDTH-1:0] s3;
        logic [WIDTH-1:0] out;
    } pwrs_sync_s;

    pwrs_sync_s q;
    pwrs_sync_s d;

    // ------------------------------------------------------------------
    // elaboration check
    // ------------------------------------------------------------------
    if (WIDTH < 1)
    begin : g_chk
        $error("flag width must be at least one");
    end

    // shift chain; the output bit only changes when stages two and three agree
    always_comb
    begin
        d = q;
        d.s1 = asyncIn;
        d.s2 = q.s1;
        d.s3 = q.s2;
        d.out = (q.s2 & q.s3) | (q.out & (q.s2 ^ q.s3));
    end

    // state register
    always_ff @(posedge clock)
    begin
        if (reset)
        begin
            q <= '0;
        end
        else
        begin
            q <= d;
        end
    end

    assign syncOut = q.out;

endmodule : pwrs_flag_sync

`default_nettype wire

// ===== src/pwrs_sequencer.sv
// module: power-up, undervoltage lockout and register access lock with AXI4-Lite
//
// Overview of operation
// - reset holds internal reset on and the output at high impedance
// - rising power-on flag starts the release counter
// - normal output only after release time and upper undervoltage flag
// - supply below falling power-on threshold reasserts reset, high impedance
// - below lower undervoltage threshold output grounds until upper reached
// - lockout engages only after the lockout enable delay
// - lockout releases only after the lockout disable delay
// - recovery above lower threshold during enable delay keeps normal output
// - power-on drop during enable delay goes straight to high impedance
// - locked after power-up; all register reads and all writes except to 0x24 refused
// - correct 30-bit code at 0x24 within 8 ms unlocks access
// - every power cycle restores the default lock
// - permanent lock after power cycle rejects every access
// - permanent lock ignores the unlock code; only reset or a power-up with permanentLockStored low clears it
`timescale 1ns/1ps
`default_nettype none

module pwrs_sequencer #(
    parameter int UNLOCK_WINDOW_CYCLES = pwrs_pkg::UNLOCK_WINDOW_CYCLES,
    parameter int ENABLE_DELAY_CYCLES = pwrs_pkg::LOCKOUT_ENABLE_CYCLES,
    parameter int DISABLE_DELAY_CYCLES = pwrs_pkg::LOCKOUT_DISABLE_CYCLES,
    parameter int TRIM_W = pwrs_pkg::TRIM_W_DEFAULT,
    // arbitrary value, replace per product
    parameter logic [29:0] UNLOCK_CODE = 30'h0ABC_1234
) (
    input wire logic clock,
    input wire logic reset,
    input wire logic risingPowerOnFlag,
    input wire logic fallingPowerOnFlag,
    input wire logic upperUndervoltageFlag,
    input wire logic lowerUndervoltageFlag,
    input wire logic permanentLockStored,
    output logic outputDriveEnable,
    output logic outputPullGround,
    output logic internalReset,
    output logic [TRIM_W-1:0] fineSensitivity,
    output logic [TRIM_W-1:0] zeroFieldOutputTrim,
    output logic permanentLockProgram,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [pwrs_pkg::AXI_ADDR_W-1:0] s_axi_awaddr,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    output logic [1:0] s_axi_bresp,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    input wire logic [pwrs_pkg::AXI_ADDR_W-1:0] s_axi_araddr,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp
);
    import pwrs_pkg::*;

    // ------------------------------------------------------------------
    // elaboration checks
    // ------------------------------------------------------------------
    if (UNLOCK_WINDOW_CYCLES < 1 || UNLOCK_WINDOW_CYCLES > 2**WINDOW_W)
    begin : g_chk_window
        $error("unlock window does not fit its counter");
    end
    if (ENABLE_DELAY_CYCLES < 1 || ENABLE_DELAY_CYCLES > 2**COUNT_W
        || DISABLE_DELAY_CYCLES < 1 || DISABLE_DELAY_CYCLES > 2**COUNT_W)
    begin : g_chk_delay
        $error("lockout delays do not fit the counter");
    end
    if (TRIM_W < 1 || TRIM_W > 32)
    begin : g_chk_trim
        $error("trim width must be 1 to 32");
    end

    typedef struct packed {
        pwrs_state_e st;
        logic [COUNT_W-1:0] cnt;
        logic [WINDOW_W-1:0] winCnt;
        logic winOpen;
        logic unlocked;
        logic permLock;
        logic drive;
        logic ground;
        logic rstOut;
        logic [COUNT_W-1:0] relTime;
        logic [TRIM_W-1:0] fineSens;
        logic [TRIM_W-1:0] zeroTrim;
        logic lockProg;
        logic awHave;
        logic [AXI_ADDR_W-1:0] awAddr;
        logic wHave;
        logic [31:0] wData;
        logic [3:0] wStrb;
        logic bValid;
        logic [1:0] bResp;
        logic rValid;
        logic [31:0] rData;
        logic [1:0] rResp;
    } pwrs_regs_s;

    pwrs_regs_s q;
    pwrs_regs_s d;
    logic [3:0] flagsSync;
    logic porHighS;
    logic porLowS;
    logic uvHighS;
    logic uvLowS;

    // byte-lane merge of a write into a stored word
    function automatic logic [31:0] mergeBytes(input logic [31:0] oldW,
        input logic [31:0] newW, input logic [3:0] strb);
        logic [31:0] res;
        res = oldW;
        for (int i = 0; i < 4; i++)
        begin
            if (strb[i])
            begin
                res[8*i +: 8] = newW[8*i +: 8];
            end
        end
        return res;
    endfunction : mergeBytes

    // ------------------------------------------------------------------
    // comparator flag synchronisers
    // ------------------------------------------------------------------
    pwrs_flag_sync #(
        .WIDTH(4)
    ) u_flag_sync (
        .clock(clock),
        .reset(reset),
        .asyncIn({lowerUndervoltageFlag, upperUndervoltageFlag,
                  fallingPowerOnFlag, risingPowerOnFlag}),
        .syncOut(flagsSync)
    );

    assign porHighS = flagsSync[0];
    assign porLowS = flagsSync[1];
    assign uvHighS = flagsSync[2];
    assign uvLowS = flagsSync[3];

    // ------------------------------------------------------------------
    // next-state logic
    // ------------------------------------------------------------------
    always_comb
    begin
        d = q;
        // unlock window runs from power-up until it expires
        if (q.winOpen)
        begin
            d.winCnt = q.winCnt + 20'h0_0001;
            if (q.winCnt == WINDOW_W'(UNLOCK_WINDOW_CYCLES - 1))
            begin
                d.winOpen = 1'b0;
            end
        end
        // output sequencer
        case (q.st)
            ST_HIZ:
            begin
                d.cnt = '0;
                if (porHighS)
                begin
                    d.st = ST_RELEASE;
                    d.winOpen = 1'b1;
                    d.winCnt = '0;
                    d.permLock = permanentLockStored;
                end
            end
            ST_RELEASE:
            begin
                if (!porLowS)
                begin
                    d.st = ST_HIZ;
                end
                else if (q.cnt >= q.relTime && uvHighS)
                begin
                    d.st = ST_NORMAL;
                    d.cnt = '0;
                end
                else if (q.cnt < q.relTime)
                begin
                    d.cnt = q.cnt + 16'h0001;
                end
            end
            ST_NORMAL:
            begin
                d.cnt = '0;
                if (!porLowS)
                begin
                    d.st = ST_HIZ;
                end
                else if (!uvLowS)
                begin
                    d.st = ST_UV_PEND;
                end
            end
            ST_UV_PEND:
            begin
                d.cnt = q.cnt + 16'h0001;
                if (!porLowS)
                begin
                    d.st = ST_HIZ;
                end
                else if (uvLowS)
                begin
                    d.st = ST_NORMAL;
                end
                else if (q.cnt == COUNT_W'(ENABLE_DELAY_CYCLES - 1))
                begin
                    d.st = ST_LOCKOUT;
                end
            end
            ST_LOCKOUT:
            begin
                d.cnt = '0;
                if (!porLowS)
                begin
                    d.st = ST_HIZ;
                end
                else if (uvHighS)
                begin
                    d.st = ST_UV_EXIT;
                end
            end
            ST_UV_EXIT:
            begin
                d.cnt = q.cnt + 16'h0001;
                if (!porLowS)
                begin
                    d.st = ST_HIZ;
                end
                else if (!uvHighS)
                begin
                    d.st = ST_LOCKOUT;
                end
                else if (q.cnt == COUNT_W'(DISABLE_DELAY_CYCLES - 1))
                begin
                    d.st = ST_NORMAL;
                end
            end
            default:
            begin
                d.st = ST_HIZ;
                d.cnt = '0;
            end
        endcase
        if (d.st != q.st)
        begin
            d.cnt = '0;
        end
        // response channels retire on their ready
        if (q.bValid && s_axi_bready)
        begin
            d.bValid = 1'b0;
        end
        if (q.rValid && s_axi_rready)
        begin
            d.rValid = 1'b0;
        end
        // address and data captured independently
        if (s_axi_awvalid && !q.awHave && !q.bValid)
        begin
            d.awHave = 1'b1;
            d.awAddr = s_axi_awaddr;
        end
        if (s_axi_wvalid && !q.wHave && !q.bValid)
        begin
            d.wHave = 1'b1;
            d.wData = s_axi_wdata;
            d.wStrb = s_axi_wstrb;
        end
        // write executes once both halves are held
        if (q.awHave && q.wHave && !q.bValid)
        begin
            d.awHave = 1'b0;
            d.wHave = 1'b0;
            d.bValid = 1'b1;
            d.bResp = RESP_OKAY;
            if (q.permLock)
            begin
                d.bResp = RESP_SLVERR;
            end
            else if (q.awAddr == REG_UNLOCK_CODE)
            begin
                if (q.winOpen
                    && q.wData[UNLOCK_CODE_W-1:0] == UNLOCK_CODE)
                begin
                    d.unlocked = 1'b1;
                end
            end
            else if (!q.unlocked)
            begin
                d.bResp = RESP_SLVERR;
            end
            else
            begin
                case (q.awAddr)
                    REG_STATUS: d.bResp = RESP_OKAY;
                    REG_RELEASE_TIME: d.relTime = COUNT_W'(mergeBytes(
                        32'(q.relTime), q.wData, q.wStrb));
                    REG_FINE_SENS: d.fineSens = TRIM_W'(mergeBytes(
                        32'(q.fineSens), q.wData, q.wStrb));
                    REG_ZERO_TRIM: d.zeroTrim = TRIM_W'(mergeBytes(
                        32'(q.zeroTrim), q.wData, q.wStrb));
                    REG_LOCK_CTRL: d.lockProg = q.wStrb[LOCK_CTRL_BIT / 8]
                        ? q.wData[LOCK_CTRL_BIT] : q.lockProg;
                    default: d.bResp = RESP_DECERR;
                endcase
            end
        end
        // read answers in the cycle after the address is taken
        if (s_axi_arvalid && !q.rValid)
        begin
            d.rValid = 1'b1;
            d.rData = '0;
            d.rResp = RESP_OKAY;
            if (q.permLock || !q.unlocked)
            begin
                d.rResp = RESP_SLVERR;
            end
            else
            begin
                case (s_axi_araddr)
                    REG_STATUS:
                    begin
                        d.rData[STATUS_STATE_LSB +: 6] = q.st;
                        d.rData[STATUS_UNLOCKED_BIT] = q.unlocked;
                        d.rData[STATUS_PERMLOCK_BIT] = q.permLock;
                        d.rData[STATUS_WINDOW_BIT] = q.winOpen;
                    end
                    REG_RELEASE_TIME: d.rData = 32'(q.relTime);
                    REG_FINE_SENS: d.rData = 32'(q.fineSens);
                    REG_ZERO_TRIM: d.rData = 32'(q.zeroTrim);
                    REG_LOCK_CTRL: d.rData[LOCK_CTRL_BIT] = q.lockProg;
                    REG_UNLOCK_CODE: d.rResp = RESP_SLVERR;
                    default: d.rResp = RESP_DECERR;
                endcase
            end
        end
        // losing power closes access and the window again
        if (d.st == ST_HIZ)
        begin
            d.unlocked = 1'b0;
            d.winOpen = 1'b0;
        end
        d.drive = (d.st != ST_HIZ) && (d.st != ST_RELEASE);
        d.ground = (d.st == ST_LOCKOUT) || (d.st == ST_UV_EXIT);
        d.rstOut = (d.st == ST_HIZ) || (d.st == ST_RELEASE);
    end

    // state register; reset is power-on reset
    always_ff @(posedge clock)
    begin
        if (reset)
        begin
            q <= '0;
            q.st <= ST_HIZ;
            q.rstOut <= 1'b1;
            q.relTime <= RELEASE_TIME_RESET;
        end
        else
        begin
            q <= d;
        end
    end

    // ------------------------------------------------------------------
    // outputs
    // ------------------------------------------------------------------
    assign outputDriveEnable = q.drive;
    assign outputPullGround = q.ground;
    assign internalReset = q.rstOut;
    assign fineSensitivity = q.fineSens;
    assign zeroFieldOutputTrim = q.zeroTrim;
    assign permanentLockProgram = q.lockProg;
    assign s_axi_awready = !q.awHave && !q.bValid;
    assign s_axi_wready = !q.wHave && !q.bValid;
    assign s_axi_bvalid = q.bValid;
    assign s_axi_bresp = q.bResp;
    assign s_axi_arready = !q.rValid;
    assign s_axi_rvalid = q.rValid;
    assign s_axi_rdata = q.rData;
    assign s_axi_rresp = q.rResp;

    // ------------------------------------------------------------------
    // assertions
    // ------------------------------------------------------------------
    default clocking cbDef @(posedge clock);
    endclocking
    default disable iff (reset);

    a_reset_hiz: assert property ($fell(reset) |-> q.st == ST_HIZ
        && !outputDriveEnable && internalReset)
        else $error("output not at high impedance after reset");
    a_release_start: assert property (q.st == ST_HIZ && porHighS
        |=> q.st == ST_RELEASE && q.cnt == '0)
        else $error("release counter did not start");
    a_release_cond: assert property ((q.st == ST_NORMAL
        && $past(q.st) == ST_RELEASE)
        |-> $past(q.cnt) >= $past(q.relTime) && $past(uvHighS))
        else $error("normal output before release conditions");
    a_power_drop: assert property (!porLowS && q.st != ST_HIZ
        |=> q.st == ST_HIZ ##1 internalReset && !outputDriveEnable)
        else $error("power-on drop did not return to high impedance");
    a_lockout_ground: assert property (q.st == ST_LOCKOUT
        |-> outputPullGround && outputDriveEnable)
        else $error("lockout does not ground the output");
    a_enable_delay: assert property ((q.st == ST_UV_PEND
        ##1 q.st == ST_LOCKOUT)
        |-> $past(q.cnt) == COUNT_W'(ENABLE_DELAY_CYCLES - 1))
        else $error("lockout engaged at wrong delay");
    a_disable_delay: assert property ((q.st == ST_UV_EXIT
        ##1 q.st == ST_NORMAL)
        |-> $past(q.cnt) == COUNT_W'(DISABLE_DELAY_CYCLES - 1))
        else $error("lockout released at wrong delay");
    a_uv_recover: assert property (q.st == ST_UV_PEND && uvLowS
        && porLowS |=> q.st == ST_NORMAL)
        else $error("recovery during enable delay lost");
    a_locked_read: assert property (s_axi_arvalid && s_axi_arready
        && !q.unlocked |=> s_axi_rvalid && s_axi_rresp == RESP_SLVERR
        && s_axi_rdata == 32'h0000_0000)
        else $error("locked read not refused");
    a_relock_power: assert property (q.st == ST_HIZ
        |-> !q.unlocked && !q.winOpen)
        else $error("lock not restored by power cycle");
    a_perm_unlock: assert property (q.permLock |-> !q.unlocked)
        else $error("unlock accepted under permanent lock");
    a_late_code: assert property (!q.winOpen && !q.unlocked
        |=> !q.unlocked)
        else $error("unlock after window closed");
    a_perm_sample: assert property (q.st != ST_HIZ
        && $past(q.st) != ST_HIZ |-> $stable(q.permLock))
        else $error("permanent lock changed outside power-up");

    c_normal: cover property (q.st == ST_RELEASE ##1 q.st == ST_NORMAL);
    c_lockout: cover property (q.st == ST_UV_EXIT ##1 q.st == ST_NORMAL);
    c_direct_hiz: cover property (q.st == ST_UV_PEND ##1 q.st == ST_HIZ);
    c_unlock: cover property ($rose(q.unlocked));

endmodule : pwrs_sequencer

`default_nettype wire

// ===== tb/pwrs_supply_model.sv
// supply model: turns a supply level into the four comparator flags
`timescale 1ns/1ps
`default_nettype none

module pwrs_supply_model (
    input wire logic [1:0] level,
    output logic risingPowerOnFlag,
    output logic fallingPowerOnFlag,
    output logic upperUndervoltageFlag,
    output logic lowerUndervoltageFlag
);
    // ------------------------------------------------------------------
    // thresholds
    // ------------------------------------------------------------------
    // level 0 off, 1 between falling por and lower uv, 2 mid, 3 full
    assign fallingPowerOnFlag = (level >= 2'h1);
    assign risingPowerOnFlag = (level >= 2'h2);
    assign lowerUndervoltageFlag = (level >= 2'h2);
    assign upperUndervoltageFlag = (level == 2'h3);
endmodule : pwrs_supply_model
`default_nettype wire

// ===== tb/power_sequencer_with_access_lock_bench.sv
// bench: supply sequencing and register lock through AXI4-Lite
`timescale 1ns/1ps
`default_nettype none

module power_sequencer_with_access_lock_bench;
    import pwrs_pkg::*;
    logic clock = 1'b0;
    logic reset = 1'b1;
    logic [1:0] level = 2'h0;
    logic rp, fp, up, lp, drv, pg, ir, plp;
    logic lockStored = 1'b0;
    logic [8:0] fs, zt;
    logic s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0;
    logic s_axi_arvalid = 0, s_axi_rready = 0;
    logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
    logic s_axi_rvalid;
    logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
    logic [31:0] s_axi_wdata = 32'h0000_0000, s_axi_rdata;
    logic [1:0] s_axi_bresp, s_axi_rresp, r;
    logic [31:0] d;
    int miscompares = 0, check_count = 0, cycles = 0, n;
    localparam logic [29:0] CODE = 30'h0ABC_1234;

    // ------------------------------------------------------------------
    // clock, design, supply
    // ------------------------------------------------------------------
    always #4 clock = ~clock;
    pwrs_sequencer #(.UNLOCK_WINDOW_CYCLES(200), .ENABLE_DELAY_CYCLES(20),
        .DISABLE_DELAY_CYCLES(20), .UNLOCK_CODE(CODE)) u_pwrs_sequencer (
        .clock(clock), .reset(reset), .risingPowerOnFlag(rp),
        .fallingPowerOnFlag(fp), .upperUndervoltageFlag(up),
        .lowerUndervoltageFlag(lp), .permanentLockStored(lockStored),
        .outputDriveEnable(drv), .outputPullGround(pg), .internalReset(ir),
        .fineSensitivity(fs), .zeroFieldOutputTrim(zt),
        .permanentLockProgram(plp), .s_axi_awvalid(s_axi_awvalid),
        .s_axi_awready(s_axi_awready), .s_axi_awaddr(s_axi_awaddr),
        .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
        .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(4'hF),
        .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
        .s_axi_bresp(s_axi_bresp), .s_axi_arvalid(s_axi_arvalid),
        .s_axi_arready(s_axi_arready), .s_axi_araddr(s_axi_araddr),
        .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
        .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp));
    pwrs_supply_model u_pwrs_supply_model (.level(level),
        .risingPowerOnFlag(rp), .fallingPowerOnFlag(fp),
        .upperUndervoltageFlag(up), .lowerUndervoltageFlag(lp));

    // ------------------------------------------------------------------
    // tasks
    // ------------------------------------------------------------------
    task automatic stop_test;
        $display("checks %0d mismatches %0d", check_count, miscompares);
        if (miscompares == 0 && check_count > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask : stop_test

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        check_count++;
        if (got !== exp)
        begin
            miscompares++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk

    // handshake signals are read at the low phase, stable up to the edge
    task automatic wr(input logic [7:0] a, input logic [31:0] v);
        logic aT, wT, bT;
        s_axi_awaddr <= a;
        s_axi_wdata <= v;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        bT = 1'b0;
        while (!bT)
        begin
            @(negedge clock);
            aT = s_axi_awvalid && s_axi_awready;
            wT = s_axi_wvalid && s_axi_wready;
            bT = s_axi_bvalid;
            r = s_axi_bresp;
            @(posedge clock);
            if (aT) s_axi_awvalid <= 1'b0;
            if (wT) s_axi_wvalid <= 1'b0;
        end
        s_axi_bready <= 1'b0;
        @(posedge clock);
    endtask : wr

    task automatic rd(input logic [7:0] a);
        logic aT, rT;
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        rT = 1'b0;
        while (!rT)
        begin
            @(negedge clock);
            aT = s_axi_arvalid && s_axi_arready;
            rT = s_axi_rvalid;
            r = s_axi_rresp;
            d = s_axi_rdata;
            @(posedge clock);
            if (aT) s_axi_arvalid <= 1'b0;
        end
        s_axi_rready <= 1'b0;
        @(posedge clock);
    endtask : rd

    // waits for the output drive or ground level, counting cycles
    task automatic waitOut(input logic g, input logic v);
        n = 0;
        while ((g ? pg : drv) !== v && n < 3000)
        begin
            @(posedge clock);
            n++;
        end
    endtask : waitOut

    // ------------------------------------------------------------------
    // timeout and main sequence
    // ------------------------------------------------------------------
    always @(posedge clock)
    begin
        cycles <= cycles + 1;
        if (cycles == 20000)
        begin
            miscompares++;
            stop_test();
        end
    end

    initial
    begin
        repeat (20) @(posedge clock);
        reset <= 1'b0;
        @(posedge clock);
        chk(32'({ir, drv}), 32'h0000_0002);
        rd(REG_STATUS);
        chk(32'(r), 32'(RESP_SLVERR));
        wr(REG_FINE_SENS, 32'h0000_0003);
        chk(32'({r, fs}), 32'h0000_0400);
        level <= 2'h3;
        repeat (8) @(posedge clock);
        wr(REG_UNLOCK_CODE, 32'(CODE));
        chk(32'(r), 32'(RESP_OKAY));
        wr(REG_RELEASE_TIME, 32'h0000_000A);
        wr(REG_FINE_SENS, 32'h0000_0005);
        wr(REG_ZERO_TRIM, 32'h0000_0007);
        chk(32'({fs, zt}), 32'h0000_0A07);
        wr(REG_LOCK_CTRL, 32'h0000_0001);
        rd(REG_STATUS);
        chk(32'({plp, r}), 32'h0000_0004);
        chk(d, 32'h0000_0504);
        rd(REG_UNLOCK_CODE);
        chk(32'(r), 32'(RESP_SLVERR));
        rd(8'h40);
        chk(32'(r), 32'(RESP_DECERR));
        waitOut(1'b0, 1'b1);
        chk(32'({ir, drv}), 32'h0000_0001);
        level <= 2'h1;
        repeat (10) @(posedge clock);
        level <= 2'h3;
        repeat (8) @(posedge clock);
        chk(32'({pg, drv}), 32'h0000_0001);
        level <= 2'h1;
        waitOut(1'b1, 1'b1);
        chk(32'(n >= 20 && n < 30), 32'h0000_0001);
        level <= 2'h3;
        waitOut(1'b1, 1'b0);
        chk(32'({pg, n >= 20 && n < 30}), 32'h0000_0001);
        level <= 2'h0;
        repeat (10) @(posedge clock);
        chk(32'({ir, drv, pg}), 32'h0000_0004);
        level <= 2'h3;
        repeat (8) @(posedge clock);
        rd(REG_STATUS);
        chk(32'(r), 32'(RESP_SLVERR));
        repeat (250) @(posedge clock);
        wr(REG_UNLOCK_CODE, 32'(CODE));
        rd(REG_STATUS);
        chk(32'(r), 32'(RESP_SLVERR));
        lockStored <= 1'b1;
        level <= 2'h1;
        repeat (10) @(posedge clock);
        level <= 2'h0;
        repeat (7) @(posedge clock);
        chk(32'({ir, drv, pg}), 32'h0000_0004);
        level <= 2'h3;
        repeat (8) @(posedge clock);
        wr(REG_UNLOCK_CODE, 32'(CODE));
        chk(32'(r), 32'(RESP_SLVERR));
        rd(REG_STATUS);
        chk(32'(r), 32'(RESP_SLVERR));
        stop_test();
    end
endmodule : power_sequencer_with_access_lock_bench
`default_nettype wire
